// ### rtl/acs_regs.svh
// Offsets, bit positions, reset values and timing counts of the calibration sequencer.
// Assumes a 40 MHz sampling clock; all timing counts are in core clock cycles.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_ADDR_CFG 4'h0
`define ACS_ADDR_ADJ 4'h4
`define ACS_ADDR_VAL 4'h5
`define ACS_CAL_BIT 15
`define ACS_PDI_BIT 11
`define ACS_PDQ_BIT 10
`define ACS_CSS_BIT 14
`define ACS_SSC_BIT 7
`define ACS_RUN_BIT 0
`define ACS_CFG_RST 16'h0000
`define ACS_ADJ_RST 16'h4000
`define ACS_NWORDS 239
`define ACS_NREADS 240
`define ACS_FLUSH_CYC 60
`define ACS_T_CAL_L 1280
`define ACS_T_CAL_H 1280
`define ACS_CAL_FULL 100000
`define ACS_CAL_LIN 60000
`define ACS_DLY_SHORT 1000000
`define ACS_DLY_LONG 4000000
`endif

// ### rtl/acs_pkg.sv
// Types shared by the calibration sequencer files.
// Assumes acs_regs.svh supplies the numeric constants.
package acs_pkg;
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_CAL, ST_HOLD, ST_FLUSH} acs_state_t;
  typedef logic [15:0] acs_word_t;
  typedef logic [3:0][11:0] acs_bus_t;
endpackage

// ### rtl/acs_req_if.sv
// Carrier between the sequencer core and its request qualifier.
// Assumes both ends share core_clk_i.
`timescale 1ns/1ps
`default_nettype none
interface acs_req_if;
  logic req_lvl;
  logic start_pls;
  modport qual (input req_lvl, output start_pls);
  modport core (output req_lvl, input start_pls);
endinterface
`default_nettype wire

// ### rtl/acs_req_qual.sv
// Low-then-high filter on the combined calibration request level.
// Assumes req_lvl is already synchronised to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_req_qual #(
  parameter int unsigned T_L = `ACS_T_CAL_L,
  parameter int unsigned T_H = `ACS_T_CAL_H
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  acs_req_if.qual rq
);
  logic [31:0] lo_cnt_ff, nxt_lo_cnt;
  logic [31:0] hi_cnt_ff, nxt_hi_cnt;
  logic armed_ff, nxt_armed;
  logic fired_ff, nxt_fired;
  logic pls_ff, nxt_pls;

  assign rq.start_pls = pls_ff;

  always_comb begin
    nxt_lo_cnt = lo_cnt_ff;
    nxt_hi_cnt = 32'h0;
    nxt_armed = armed_ff;
    nxt_fired = fired_ff;
    nxt_pls = 1'b0;
    if (!rq.req_lvl) begin
      // level must return low before rearming
      nxt_fired = 1'b0;
      if (lo_cnt_ff < T_L) begin
        nxt_lo_cnt = lo_cnt_ff + 32'h1;
      end
      nxt_armed = (lo_cnt_ff + 32'h1 >= T_L);
    end else begin
      nxt_lo_cnt = 32'h0;
      if (armed_ff && !fired_ff) begin
        nxt_hi_cnt = hi_cnt_ff + 32'h1;
        if (hi_cnt_ff + 32'h1 >= T_H) begin
          nxt_pls = 1'b1;
          nxt_fired = 1'b1;
          nxt_armed = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lo_cnt_ff <= 32'h0;
      hi_cnt_ff <= 32'h0;
      armed_ff <= 1'b0;
      fired_ff <= 1'b0;
      pls_ff <= 1'b0;
    end else begin
      lo_cnt_ff <= nxt_lo_cnt;
      hi_cnt_ff <= nxt_hi_cnt;
      armed_ff <= nxt_armed;
      fired_ff <= nxt_fired;
      pls_ff <= nxt_pls;
    end
  end

  chk_qual_needs_high: assert property (@(posedge core_clk_i) disable iff (srst_i)
    pls_ff |-> $past(rq.req_lvl) && $past(hi_cnt_ff) + 32'h1 >= T_H)
    else $error("start without a long enough high phase");
  // Helper: request has stayed high since the last start
  logic held_ff;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !rq.req_lvl) begin
      held_ff <= 1'b0;
    end else if (pls_ff) begin
      held_ff <= 1'b1;
    end
  end

  chk_qual_single_start: assert property (@(posedge core_clk_i) disable iff (srst_i)
    held_ff |-> !pls_ff)
    else $error("second start before the request went low");
endmodule
`default_nettype wire

// ### rtl/acs_seq.sv
// Calibration sequencer: request qualification, power-up delay, run, suspend, flush.
// Assumes pins are asynchronous to core_clk_i and registers arrive as decoded word accesses.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
// Contract
// - Start needs long low then long high
// - Pin ORed with register bit, both low
// - Same procedure from every start source
// - Power-up calibration after selected delay
// - Delay-select change may start a calibration
// - Request high at power-up skips calibration
// - Sequence select chooses trim plus linearity
// - Constants kept in word-addressed array
// - Read 240 words, dummy first
// - Restore 239 words plus two dummies
// - Both channels down suspends calibration
// - Data and over-range low while calibrating
// - Output data clock never stops
// - Sixty cycles flush after active falls
// - Active flag exactly spans calibration
// - Per-channel power-down, pin ORed bit
module acs_seq #(
  parameter int unsigned T_CAL_L = `ACS_T_CAL_L,
  parameter int unsigned T_CAL_H = `ACS_T_CAL_H,
  parameter int unsigned CAL_FULL = `ACS_CAL_FULL,
  parameter int unsigned CAL_LIN = `ACS_CAL_LIN,
  parameter int unsigned DLY_SHORT = `ACS_DLY_SHORT,
  parameter int unsigned DLY_LONG = `ACS_DLY_LONG
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic calibrate_request_i,
  input wire logic powerup_cal_delay_select_i,
  input wire logic i_channel_powerdown_i,
  input wire logic q_channel_powerdown_i,
  input wire logic extended_control_select_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire acs_pkg::acs_word_t reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire acs_pkg::acs_word_t cal_word_i,
  input wire acs_pkg::acs_bus_t samp_i,
  input wire logic [1:0] over_range_i,
  output acs_pkg::acs_bus_t samp_o,
  output logic [1:0] over_range_o,
  output logic output_data_clock_o,
  output logic calibration_active_o,
  output logic rin_trim_active_o,
  output logic i_channel_off_o,
  output logic q_channel_off_o
);
  import acs_pkg::*;

  localparam int unsigned FLUSH = `ACS_FLUSH_CYC;
  localparam logic [7:0] NWORDS = 8'(`ACS_NWORDS);

  function automatic logic [31:0] dec_sat(input logic [31:0] v);
    return (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction

  // Pin order: request, delay select, I down, Q down, select
  logic [4:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
    end else begin
      pin_s1_ff <= {extended_control_select_n_i, q_channel_powerdown_i,
                    i_channel_powerdown_i, powerup_cal_delay_select_i, calibrate_request_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  logic extended_control_mode;
  logic pd_i, pd_q, both_pd;
  acs_word_t cfg_ff, nxt_cfg;
  acs_word_t adj_ff, nxt_adj;
  logic [7:0] val_idx_ff, nxt_val_idx;
  acs_word_t rdata_ff, nxt_rdata;
  acs_word_t arr_ff [`ACS_NWORDS];
  acs_word_t nxt_arr [`ACS_NWORDS];
  acs_state_t state_ff, nxt_state;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [7:0] cal_idx_ff, nxt_cal_idx;
  logic css_run_ff, nxt_css_run;
  logic skip_ff, nxt_skip;
  logic dly_prev_ff;
  logic dly_change;
  logic cal_act_ff, blank_ff, trim_ff, pdi_ff, pdq_ff, output_data_clock_ff;
  acs_bus_t samp_ff;
  logic [1:0] ovr_ff;
  logic val_acc, reg_en;

  acs_req_if rq ();
  acs_req_qual #(.T_L(T_CAL_L), .T_H(T_CAL_H)) u_qual (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .rq(rq)
  );

  // select pin low enables the register path
  assign extended_control_mode = ~pin_s2_ff[4];
  assign reg_en = extended_control_mode;
  assign rq.req_lvl = pin_s2_ff[0] | (extended_control_mode & cfg_ff[`ACS_CAL_BIT]);
  assign pd_i = pin_s2_ff[2] | (extended_control_mode & cfg_ff[`ACS_PDI_BIT]);
  assign pd_q = pin_s2_ff[3] | (extended_control_mode & cfg_ff[`ACS_PDQ_BIT]);
  assign both_pd = pd_i & pd_q;
  assign dly_change = pin_s2_ff[1] ^ dly_prev_ff;
  assign val_acc = reg_en && (reg_wr_i || reg_rd_i) && reg_addr_i == `ACS_ADDR_VAL &&
                   adj_ff[`ACS_SSC_BIT];

  // Register group
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_adj = adj_ff;
    nxt_val_idx = val_idx_ff;
    nxt_rdata = rdata_ff;
    if (reg_en && reg_wr_i && reg_addr_i == `ACS_ADDR_CFG) begin
      nxt_cfg = reg_wdata_i;
    end
    if (reg_en && reg_wr_i && reg_addr_i == `ACS_ADDR_ADJ) begin
      nxt_adj = reg_wdata_i & `ACS_ADJ_RST | reg_wdata_i & 16'h0080;
    end
    // index advances per access, cleared on enable
    if (val_acc && val_idx_ff != 8'hff) begin
      nxt_val_idx = val_idx_ff + 8'h1;
    end
    if (nxt_adj[`ACS_SSC_BIT] && !adj_ff[`ACS_SSC_BIT]) begin
      nxt_val_idx = 8'h0;
    end
    if (reg_en && reg_rd_i) begin
      case (reg_addr_i)
        `ACS_ADDR_CFG: nxt_rdata = cfg_ff;
        `ACS_ADDR_ADJ: nxt_rdata = adj_ff | {15'h0, cal_act_ff};
        `ACS_ADDR_VAL: begin
          if (adj_ff[`ACS_SSC_BIT] && val_idx_ff != 8'h0 && val_idx_ff <= NWORDS) begin
            nxt_rdata = arr_ff[val_idx_ff - 8'h1];
          end else begin
            nxt_rdata = 16'h0000;
          end
        end
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cfg_ff <= `ACS_CFG_RST;
      adj_ff <= `ACS_ADJ_RST;
      val_idx_ff <= 8'h0;
      rdata_ff <= 16'h0000;
    end else begin
      cfg_ff <= nxt_cfg;
      adj_ff <= nxt_adj;
      val_idx_ff <= nxt_val_idx;
      rdata_ff <= nxt_rdata;
    end
  end

  // Constant array; calibration writes take priority over restore writes
  always_comb begin
    nxt_arr = arr_ff;
    // array filled by the running calibration
    if (state_ff == ST_CAL && !both_pd && cal_idx_ff < NWORDS) begin
      nxt_arr[cal_idx_ff] = cal_word_i;
    // restore loads words in order, dummies dropped
    end else if (val_acc && reg_wr_i && val_idx_ff < NWORDS) begin
      nxt_arr[val_idx_ff] = reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    arr_ff <= nxt_arr;
  end

  // Sequencer state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = dec_sat(cnt_ff);
    nxt_cal_idx = cal_idx_ff;
    nxt_css_run = css_run_ff;
    nxt_skip = skip_ff;
    case (state_ff)
      ST_BOOT: begin
        // request high during the wait skips calibration
        if (rq.req_lvl) begin
          nxt_skip = 1'b1;
        end
        // delay follows the select once it has settled
        if (!skip_ff && dly_change) begin
          nxt_cnt = pin_s2_ff[1] ? DLY_LONG : DLY_SHORT;
        end else if (cnt_ff == 32'h0) begin
          nxt_state = (skip_ff || rq.req_lvl) ? ST_IDLE : ST_CAL;
        end
      end
      ST_IDLE: begin
        if (rq.start_pls) begin
          nxt_state = ST_CAL;
        // select change rearms the power-up path
        end else if (dly_change) begin
          nxt_state = ST_BOOT;
          nxt_cnt = pin_s2_ff[1] ? DLY_LONG : DLY_SHORT;
          nxt_skip = 1'b0;
        end
      end
      ST_CAL: begin
        if (cal_idx_ff < NWORDS) begin
          nxt_cal_idx = cal_idx_ff + 8'h1;
        end
        // both channels down freezes the run
        if (both_pd) begin
          nxt_state = ST_HOLD;
          nxt_cnt = cnt_ff;
          nxt_cal_idx = cal_idx_ff;
        end else if (cnt_ff == 32'h0) begin
          nxt_state = ST_FLUSH;
          nxt_cnt = FLUSH - 1;
        end
      end
      ST_HOLD: begin
        nxt_cnt = cnt_ff;
        if (!both_pd) begin
          nxt_state = ST_CAL;
        end
      end
      ST_FLUSH: begin
        // pipeline flush before data is valid
        if (cnt_ff == 32'h0) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // one entry point for every start source
    // sequence select fixes the run length
    if (nxt_state == ST_CAL && state_ff != ST_CAL && state_ff != ST_HOLD) begin
      nxt_css_run = adj_ff[`ACS_CSS_BIT];
      nxt_cnt = adj_ff[`ACS_CSS_BIT] ? CAL_FULL - 1 : CAL_LIN - 1;
      nxt_cal_idx = 8'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff <= ST_BOOT;
      cnt_ff <= DLY_SHORT;
      cal_idx_ff <= 8'h0;
      css_run_ff <= 1'b1;
      skip_ff <= 1'b0;
      dly_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cal_idx_ff <= nxt_cal_idx;
      css_run_ff <= nxt_css_run;
      skip_ff <= nxt_skip;
      dly_prev_ff <= pin_s2_ff[1];
    end
  end

  // Output stage
  logic nxt_act, nxt_blank;
  assign nxt_act = nxt_state == ST_CAL || nxt_state == ST_HOLD;
  assign nxt_blank = nxt_act || nxt_state == ST_FLUSH;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cal_act_ff <= 1'b0;
      blank_ff <= 1'b0;
      trim_ff <= 1'b0;
      pdi_ff <= 1'b0;
      pdq_ff <= 1'b0;
      output_data_clock_ff <= 1'b0;
      samp_ff <= '0;
      ovr_ff <= 2'h0;
    end else begin
      cal_act_ff <= nxt_act;
      blank_ff <= nxt_blank;
      trim_ff <= nxt_state == ST_CAL && nxt_css_run && nxt_cnt >= CAL_LIN;
      pdi_ff <= pd_i;
      pdq_ff <= pd_q;
      output_data_clock_ff <= ~output_data_clock_ff;
      samp_ff[1:0] <= (nxt_blank || pd_i) ? '0 : samp_i[1:0];
      samp_ff[3:2] <= (nxt_blank || pd_q) ? '0 : samp_i[3:2];
      ovr_ff[0] <= (nxt_blank || pd_i) ? 1'b0 : over_range_i[0];
      ovr_ff[1] <= (nxt_blank || pd_q) ? 1'b0 : over_range_i[1];
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign samp_o = samp_ff;
  assign over_range_o = ovr_ff;
  assign output_data_clock_o = output_data_clock_ff;
  assign calibration_active_o = cal_act_ff;
  assign rin_trim_active_o = trim_ff;
  assign i_channel_off_o = pdi_ff;
  assign q_channel_off_o = pdq_ff;

  // Helper: blanked cycles since active fell
  logic [7:0] post_cnt_ff;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || cal_act_ff) begin
      post_cnt_ff <= 8'h0;
    end else if (blank_ff) begin
      post_cnt_ff <= post_cnt_ff + 8'h1;
    end
  end

  chk_blank_during_cal: assert property (@(posedge core_clk_i) disable iff (srst_i)
    cal_act_ff |-> samp_o == '0 && over_range_o == 2'h0)
    else $error("data not low during calibration");
  chk_flush_sixty: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(blank_ff) && !$past(cal_act_ff) |-> post_cnt_ff == 8'(FLUSH))
    else $error("flush length is not sixty cycles");
  chk_output_data_clock_toggles: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $past(!srst_i) |-> output_data_clock_o != $past(output_data_clock_o))
    else $error("output data clock stalled");
  chk_active_span: assert property (@(posedge core_clk_i) disable iff (srst_i)
    calibration_active_o == (state_ff == ST_CAL || state_ff == ST_HOLD))
    else $error("active flag disagrees with state");
  chk_start_length: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(cal_act_ff) |-> cnt_ff == (css_run_ff ? CAL_FULL - 1 : CAL_LIN - 1))
    else $error("run length does not match sequence select");
  chk_suspend_both: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_ff == ST_CAL && both_pd |=> state_ff == ST_HOLD && $stable(cnt_ff))
    else $error("calibration not suspended on full power-down");
  chk_boot_skip: assert property (@(posedge core_clk_i) disable iff (srst_i)
    state_ff == ST_BOOT && cnt_ff == 32'h0 && skip_ff |=> state_ff == ST_IDLE)
    else $error("power-up calibration not skipped");
  chk_read_dummy: assert property (@(posedge core_clk_i) disable iff (srst_i)
    val_acc && reg_rd_i && val_idx_ff == 8'h0 |=> reg_rdata_o == 16'h0000)
    else $error("first read of the array is not the dummy");
  chk_index_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $rose(adj_ff[`ACS_SSC_BIT]) |-> val_idx_ff == 8'h0)
    else $error("array index not cleared on enable");
  chk_pd_or: assert property (@(posedge core_clk_i) disable iff (srst_i)
    extended_control_mode && cfg_ff[`ACS_PDI_BIT] |=> i_channel_off_o)
    else $error("register power-down ignored");

  cov_cal_done: cover property (@(posedge core_clk_i) disable iff (srst_i)
    $fell(blank_ff));
  cov_suspend: cover property (@(posedge core_clk_i) disable iff (srst_i)
    state_ff == ST_HOLD ##1 state_ff == ST_CAL);
  cov_skip: cover property (@(posedge core_clk_i) disable iff (srst_i)
    state_ff == ST_BOOT && cnt_ff == 32'h0 && skip_ff);
  cov_restore: cover property (@(posedge core_clk_i) disable iff (srst_i)
    val_acc && reg_wr_i && val_idx_ff == NWORDS - 8'h1);
endmodule
`default_nettype wire

// ### bench/acs_host.sv
// Host model: control pins and decoded register port of the sequencer.
// Assumes the bench calls its tasks from falling clock edges only.
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  input wire logic core_clk_i,
  input wire logic calibration_active_i,
  input wire logic [15:0] reg_rdata_i,
  output var logic cal_req_o,
  output var logic dly_sel_o,
  output var logic i_pd_o,
  output var logic q_pd_o,
  output var logic ecs_n_o,
  output var logic reg_wr_o,
  output var logic reg_rd_o,
  output var logic [3:0] reg_addr_o,
  output var logic [15:0] reg_wdata_o
);
  initial begin
    cal_req_o = 1'b0;
    dly_sel_o = 1'b0;
    i_pd_o = 1'b0;
    q_pd_o = 1'b0;
    ecs_n_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 4'h0;
    reg_wdata_o = 16'h0000;
  end
  task automatic bus_wait();
    int n;
    n = 0;
    while (calibration_active_i === 1'b1 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    @(negedge core_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_wait();
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus_wait();
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
  // low span, high span, final level
  task automatic cal_pulse(input int lo, input int hi, input logic fin);
    cal_req_o = 1'b0;
    repeat (lo) @(negedge core_clk_i);
    cal_req_o = 1'b1;
    repeat (hi) @(negedge core_clk_i);
    cal_req_o = fin;
  endtask
endmodule
`default_nettype wire

// ### bench/acs_tb.sv
// Self-checking bench for the calibration sequencer, short counts.
// Assumes acs_host drives pins and register strobes at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
`define CHK(a, e) chk_val(48'(a), 48'(e))
module tb;
  import acs_pkg::*;
  localparam int FULL = 300;
  localparam int LIN = 200;
  localparam logic [47:0] SAMP = 48'h123456789abc;
  localparam logic [15:0] CAL_WORD = 16'h5a5a;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cal_req, dly_sel, i_pd, q_pd, ecs_n, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  acs_bus_t samp_o;
  logic [1:0] over_range_o;
  logic [1:0] ovr_in = 2'b11;
  logic output_data_clock, active, trim, i_off, q_off;
  int fail_count = 0;
  int num_checks = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  acs_host i_host (.core_clk_i(core_clk_i), .calibration_active_i(active),
    .reg_rdata_i(reg_rdata), .cal_req_o(cal_req), .dly_sel_o(dly_sel),
    .i_pd_o(i_pd), .q_pd_o(q_pd), .ecs_n_o(ecs_n), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
  acs_seq #(.T_CAL_L(4), .T_CAL_H(4), .CAL_FULL(FULL), .CAL_LIN(LIN),
    .DLY_SHORT(20), .DLY_LONG(40)) i_dut (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .calibrate_request_i(cal_req),
    .powerup_cal_delay_select_i(dly_sel), .i_channel_powerdown_i(i_pd),
    .q_channel_powerdown_i(q_pd), .extended_control_select_n_i(ecs_n),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .cal_word_i(CAL_WORD),
    .samp_i(acs_bus_t'(SAMP)), .over_range_i(ovr_in), .samp_o(samp_o),
    .over_range_o(over_range_o), .output_data_clock_o(output_data_clock),
    .calibration_active_o(active), .rin_trim_active_o(trim),
    .i_channel_off_o(i_off), .q_channel_off_o(q_off));
  task automatic chk_val(input logic [47:0] a, input logic [47:0] e);
    num_checks++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, a, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input logic req);
    srst_i = 1'b1;
    @(negedge core_clk_i);
    i_host.cal_req_o = req;
    repeat (3) @(negedge core_clk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask
  // Waits for a run, measures it, then checks the flush span
  task automatic run_cal(input int lo, input int hi, input logic trim_exp);
    int n;
    logic seen, blank_ok, tog_ok, prev;
    n = 0;
    seen = 1'b0;
    blank_ok = 1'b1;
    tog_ok = 1'b1;
    while (active !== 1'b1 && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    `CHK(active, 1'b1);
    n = 0;
    prev = output_data_clock;
    while (active === 1'b1 && n < 2000) begin
      seen |= trim;
      blank_ok &= (samp_o === '0) && (over_range_o === 2'b00);
      @(negedge core_clk_i);
      tog_ok &= (output_data_clock !== prev);
      prev = output_data_clock;
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1);
    `CHK(seen, trim_exp);
    `CHK(blank_ok, 1'b1);
    `CHK(tog_ok, 1'b1);
    repeat (`ACS_FLUSH_CYC - 2) @(negedge core_clk_i);
    `CHK(samp_o, 48'h0);
    repeat (6) @(negedge core_clk_i);
    `CHK(samp_o, SAMP);
    `CHK(over_range_o, ovr_in);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    do_reset(1'b0);
    repeat (10) @(negedge core_clk_i);
    `CHK(active, 1'b0);
    run_cal(FULL, FULL, 1'b1);
    i_host.cal_req_o = 1'b1;
    i_host.dly_sel_o = 1'b1;
    do_reset(1'b1);
    repeat (100) @(negedge core_clk_i);
    `CHK(active, 1'b0);
    i_host.rd(`ACS_ADDR_CFG, rv);
    `CHK(rv, `ACS_CFG_RST);
    i_host.rd(`ACS_ADDR_ADJ, rv);
    `CHK(rv, `ACS_ADJ_RST);
    i_host.rd(4'h3, rv);
    `CHK(rv, 16'h0000);
    i_host.cal_pulse(2, 10, 1'b0);
    i_host.cal_pulse(8, 2, 1'b0);
    repeat (30) @(negedge core_clk_i);
    `CHK(active, 1'b0);
    i_host.cal_pulse(8, 0, 1'b1);
    run_cal(FULL, FULL, 1'b1);
    i_host.cal_req_o = 1'b0;
    i_host.wr(`ACS_ADDR_ADJ, 16'h0000);
    repeat (8) @(negedge core_clk_i);
    i_host.wr(`ACS_ADDR_CFG, 16'h8000);
    run_cal(LIN, LIN, 1'b0);
    i_host.cal_pulse(8, 8, 1'b0);
    repeat (20) @(negedge core_clk_i);
    `CHK(active, 1'b0);
    i_host.wr(`ACS_ADDR_CFG, 16'h0000);
    i_host.wr(`ACS_ADDR_ADJ, 16'h4000);
    repeat (8) @(negedge core_clk_i);
    i_host.wr(`ACS_ADDR_CFG, 16'h8000);
    run_cal(FULL, FULL, 1'b1);
    i_host.wr(`ACS_ADDR_CFG, 16'h0000);
    i_host.cal_pulse(8, 0, 1'b1);
    fork
      run_cal(FULL + 99, FULL + 101, 1'b1);
      begin
        repeat (80) @(negedge core_clk_i);
        i_host.i_pd_o = 1'b1;
        i_host.q_pd_o = 1'b1;
        repeat (100) @(negedge core_clk_i);
        `CHK(active, 1'b1);
        `CHK({i_off, q_off}, 2'b11);
        i_host.i_pd_o = 1'b0;
        i_host.q_pd_o = 1'b0;
      end
    join
    // Recalibrate after the channels come back up
    i_host.cal_pulse(8, 0, 1'b1);
    run_cal(FULL, FULL, 1'b1);
    i_host.wr(`ACS_ADDR_CFG, 16'h0800);
    repeat (2) @(negedge core_clk_i);
    `CHK({i_off, q_off}, 2'b10);
    i_host.wr(`ACS_ADDR_CFG, 16'h0000);
    i_host.ecs_n_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    i_host.wr(`ACS_ADDR_CFG, 16'h0400);
    repeat (2) @(negedge core_clk_i);
    `CHK(q_off, 1'b0);
    i_host.q_pd_o = 1'b1;
    repeat (4) @(negedge core_clk_i);
    `CHK(q_off, 1'b1);
    i_host.q_pd_o = 1'b0;
    i_host.ecs_n_o = 1'b0;
    repeat (4) @(negedge core_clk_i);
    i_host.rd(`ACS_ADDR_CFG, rv);
    `CHK(rv, 16'h0000);
    i_host.cal_req_o = 1'b0;
    ovr_in = 2'b10;
    repeat (10) @(negedge core_clk_i);
    i_host.dly_sel_o = 1'b0;
    repeat (10) @(negedge core_clk_i);
    `CHK(active, 1'b0);
    run_cal(FULL, FULL, 1'b1);
    i_host.wr(`ACS_ADDR_ADJ, 16'h4080);
    i_host.rd(`ACS_ADDR_VAL, rv);
    `CHK(rv, 16'h0000);
    i_host.rd(`ACS_ADDR_VAL, rv);
    `CHK(rv, CAL_WORD);
    i_host.wr(`ACS_ADDR_ADJ, 16'h4000);
    i_host.wr(`ACS_ADDR_ADJ, 16'h4080);
    for (int k = 0; k < `ACS_NREADS + 1; k++) begin
      i_host.wr(`ACS_ADDR_VAL, (k < `ACS_NWORDS) ? 16'(k * 37 + 1) : 16'h0000);
    end
    i_host.wr(`ACS_ADDR_ADJ, 16'h4000);
    i_host.wr(`ACS_ADDR_ADJ, 16'h4080);
    for (int k = 0; k < `ACS_NREADS; k++) begin
      i_host.rd(`ACS_ADDR_VAL, rv);
      `CHK(rv, (k == 0) ? 16'h0000 : 16'((k - 1) * 37 + 1));
    end
    i_host.wr(`ACS_ADDR_ADJ, 16'h4000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
